// File: twm_pkg.sv
package twm_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   // register offsets
   localparam logic [4:0] REG_CONFIG = 5'h14;
   localparam logic [4:0] REG_CMD    = 5'h15;
   localparam logic [4:0] REG_DATA   = 5'h16;

   // field positions
   localparam int CFG_DEV_MSB  = 15;
   localparam int CFG_DEV_LSB  = 9;
   localparam int CFG_RATE_MSB = 5;
   localparam int CFG_RATE_LSB = 4;
   localparam int CFG_EN_MSB   = 3;
   localparam int CMD_READY    = 15;
   localparam int CMD_SEL_MSB  = 11;
   localparam int CMD_SEL_LSB  = 10;
   localparam int CMD_EXEC     = 9;
   localparam int CMD_DIR      = 8;
   localparam int CMD_ADDR_MSB = 7;
   localparam int DAT_RD_LSB   = 8;
   localparam int DAT_WR_MSB   = 7;

   // reset values
   localparam logic [7:0] DEV_ADDR8_RST = 8'ha0;
   localparam logic [1:0] RATE_RST      = 2'h1;
   localparam logic [3:0] PORT_EN_RST   = 4'h0;
   localparam logic [1:0] PORT_SEL_RST  = 2'h0;
   localparam logic       DIR_RST       = 1'b1;
   localparam logic [7:0] MADDR_RST     = 8'h00;
   localparam logic [7:0] WDATA_RST     = 8'h00;

   // timing: core clock and the four bus clock rates, in kHz
   localparam int CLK_KHZ      = 100000;
   localparam int SCL_KHZ_SLOW = 50;
   localparam int SCL_KHZ_STD  = 100;
   localparam int SCL_KHZ_FAST = 400;
   localparam int SCL_KHZ_TOP  = 2000;
   localparam int QUARTER_W    = 10;

   // byte steps of a transfer
   localparam logic [2:0] STEP_DEV    = 3'h0;
   localparam logic [2:0] STEP_ADDR   = 3'h1;
   localparam logic [2:0] STEP_DATA   = 3'h2;
   localparam logic [2:0] STEP_DEV_RD = 3'h3;

   typedef enum logic [2:0] {TWM_IDLE, TWM_START, TWM_SEND, TWM_RSTART, TWM_RECV, TWM_STOP} twm_fsm_e;

   // quarter bus-clock period in core cycles, rounded up
   function automatic logic [QUARTER_W-1:0] twm_quarter_cycles(input logic [1:0] rate);
      int f;
      case (rate)
         2'h0:    f = SCL_KHZ_SLOW;
         2'h1:    f = SCL_KHZ_STD;
         2'h2:    f = SCL_KHZ_FAST;
         default: f = SCL_KHZ_TOP;
      endcase
      return QUARTER_W'((CLK_KHZ + 4 * f - 1) / (4 * f));
   endfunction

endpackage

// File: twm_tick_gen.sv
`timescale 1ns/1ps

module twm_tick_gen #(
   parameter int CNT_W = twm_pkg::QUARTER_W
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic             run,
   input  wire logic [1:0]       rate,
   output logic                  tick
);

   if (int'(twm_pkg::twm_quarter_cycles(2'h0)) >= 2 ** CNT_W) begin : g_chk
      $error("twm_tick_gen: CNT_W too narrow for slowest rate");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } twm_tick_s;

   twm_tick_s s;
   twm_tick_s next_s;
   logic [CNT_W-1:0] limit;

   always_comb begin
      next_s = s;
      limit = CNT_W'(twm_pkg::twm_quarter_cycles(rate));
      next_s.tick = 1'b0;
      if (!run) begin
         next_s.cnt = '0;
      end else if (s.cnt == limit - CNT_W'(1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule // twm_tick_gen

// File: twm_serial_mux.sv
`timescale 1ns/1ps

// Functional notes
// RL1: the slave device address sent is the 7-bit field at config bits 15:9, reset to the module address 0xA0.
// RL2: the lowest bit of the address byte is the read/write indicator from the direction bit.
// RL3: the bus clock rate field at config bits 5:4 selects 50 kHz, 100 kHz, 400 kHz or 2 MHz and resets to 01.
// RL4: ports 1 to 3 drive the serial bus only while their enable bit is 1, else they are GPIO; enables reset to 0.
// RL5: port 0 is GPIO whenever the serial LED function is on, otherwise it follows its enable bit.
// RL6: the read-only ready flag at command bit 15 reads 1 when a new read or write can be accepted.
// RL7: the port-select field at command bits 11:10, reset 00, picks the port that carries the transfer.
// RL8: software writes 1 to execute bit 9 to launch a transfer and the block clears that bit itself.
// RL9: direction bit 8 selects read when 1 and write when 0, resetting to 1.
// RL10: command bits 7:0, reset 0x00, hold the byte address inside the slave.
// RL11: the byte read lands in data bits 15:8 and only a launched read produces it.
// RL12: software places the write byte in data bits 7:0, reset 0x00, and the block transmits it.
// RL13: ready reads 0 during a transfer and returns to 1 only after the stop, with read data valid.
// RL14: a read writes the byte address, repeats start with the read bit, takes one byte, answers not-ack, then stops.
// RL15: software waits for ready before changing port, address or data fields or launching again.
module twm_serial_mux (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        led_serial_en,
   output logic      [3:0]  port_serial_en,
   input  wire logic [3:0]  scl_i,
   output logic      [3:0]  scl_o,
   output logic      [3:0]  scl_oe_n,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n
);

   typedef struct packed {
      logic [6:0]         dev;
      logic [1:0]         rate;
      logic [3:0]         port_en;
      logic [1:0]         port_sel;
      logic               exec;
      logic               dir;
      logic [7:0]         maddr;
      logic [7:0]         wdata;
      logic [7:0]         rx;
      twm_pkg::twm_fsm_e  st;
      logic [1:0]         q;
      logic [3:0]         bitn;
      logic [2:0]         step;
      logic [7:0]         sh;
      logic               nack;
      logic               scl_lo;
      logic               sda_lo;
      logic [3:0]         port_active;
      logic [3:0]         scl_oe_n;
      logic               sda_oe_n;
      logic [15:0]        rdata;
   } twm_core_s;

   twm_core_s s;
   twm_core_s next_s;
   logic      tick;
   logic      ready;
   logic      in_byte;
   logic      hold;
   logic      byte_end;

   twm_tick_gen u_tick (
      .core_clk (core_clk),
      .rstn     (rstn),
      .run      (s.st != twm_pkg::TWM_IDLE),
      .rate     (s.rate),
      .tick     (tick)
   );

   assign ready    = (s.st == twm_pkg::TWM_IDLE) && !s.exec;
   assign in_byte  = (s.st == twm_pkg::TWM_SEND) || (s.st == twm_pkg::TWM_RECV);
   // a slave holding the clock low stretches the high phase
   assign hold     = in_byte && (s.q == 2'h2) && !scl_i[s.port_sel];
   assign byte_end = tick && !hold && in_byte && (s.q == 2'h3) && (s.bitn == 4'h8);

   always_comb begin
      next_s = s;
      next_s.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            twm_pkg::REG_CONFIG: next_s.rdata = {s.dev, 3'h0, s.rate, s.port_en};
            twm_pkg::REG_CMD:    next_s.rdata = {ready, 3'h0, s.port_sel, s.exec, s.dir, s.maddr}; // RL6 RL13
            twm_pkg::REG_DATA:   next_s.rdata = {s.rx, s.wdata}; // RL11
            default:             next_s.rdata = '0;
         endcase
      end
      // writes while a transfer is pending or running are dropped
      if (reg_wr && ready) begin
         case (reg_addr)
            twm_pkg::REG_CONFIG: begin
               next_s.dev = reg_wdata[twm_pkg::CFG_DEV_MSB:twm_pkg::CFG_DEV_LSB];
               next_s.rate = reg_wdata[twm_pkg::CFG_RATE_MSB:twm_pkg::CFG_RATE_LSB];
               next_s.port_en = reg_wdata[twm_pkg::CFG_EN_MSB:0];
            end
            twm_pkg::REG_CMD: begin
               next_s.port_sel = reg_wdata[twm_pkg::CMD_SEL_MSB:twm_pkg::CMD_SEL_LSB];
               next_s.exec = reg_wdata[twm_pkg::CMD_EXEC];
               next_s.dir = reg_wdata[twm_pkg::CMD_DIR];
               next_s.maddr = reg_wdata[twm_pkg::CMD_ADDR_MSB:0];
            end
            twm_pkg::REG_DATA: begin
               next_s.wdata = reg_wdata[twm_pkg::DAT_WR_MSB:0]; // RL12
            end
            default: begin
            end
         endcase
      end
      // launch; a disabled port finishes at once with no bus activity
      if (s.st == twm_pkg::TWM_IDLE && s.exec) begin
         next_s.exec = 1'b0; // RL8
         if (s.port_active[s.port_sel]) begin // RL7
            next_s.st = twm_pkg::TWM_START;
            next_s.q = 2'h0;
            next_s.bitn = 4'h0;
            next_s.step = twm_pkg::STEP_DEV;
            next_s.sh = {s.dev, 1'b0}; // RL1 RL2 RL14
            next_s.nack = 1'b0;
         end
      end
      if (tick && !hold && s.st != twm_pkg::TWM_IDLE) begin
         next_s.q = s.q + 2'h1;
         case (s.st)
            twm_pkg::TWM_START, twm_pkg::TWM_RSTART: begin
               case (s.q)
                  2'h0: next_s.sda_lo = 1'b0;
                  2'h1: next_s.scl_lo = 1'b0;
                  2'h2: next_s.sda_lo = 1'b1;
                  default: begin
                     next_s.scl_lo = 1'b1;
                     next_s.st = twm_pkg::TWM_SEND;
                     next_s.bitn = 4'h0;
                     if (s.st == twm_pkg::TWM_RSTART) begin
                        next_s.sh = {s.dev, s.dir}; // RL2 RL14
                        next_s.step = twm_pkg::STEP_DEV_RD;
                     end
                  end
               endcase
            end
            twm_pkg::TWM_SEND, twm_pkg::TWM_RECV: begin
               case (s.q)
                  2'h0: next_s.sda_lo = (s.st == twm_pkg::TWM_SEND) && (s.bitn != 4'h8) && !s.sh[7]; // RL14
                  2'h1: next_s.scl_lo = 1'b0;
                  2'h2: begin
                     if (s.st == twm_pkg::TWM_SEND && s.bitn == 4'h8) begin
                        next_s.nack = sda_i;
                     end else if (s.st == twm_pkg::TWM_RECV && s.bitn != 4'h8) begin
                        next_s.sh = {s.sh[6:0], sda_i};
                     end
                  end
                  default: begin
                     next_s.scl_lo = 1'b1;
                     if (s.bitn != 4'h8) begin
                        next_s.bitn = s.bitn + 4'h1;
                        if (s.st == twm_pkg::TWM_SEND) begin
                           next_s.sh = {s.sh[6:0], 1'b0};
                        end
                     end else begin
                        next_s.bitn = 4'h0;
                        if (s.st == twm_pkg::TWM_RECV) begin
                           next_s.rx = s.sh; // RL11
                           next_s.st = twm_pkg::TWM_STOP;
                        end else if (s.nack) begin
                           next_s.st = twm_pkg::TWM_STOP;
                        end else begin
                           case (s.step)
                              twm_pkg::STEP_DEV: begin
                                 next_s.sh = s.maddr; // RL10
                                 next_s.step = twm_pkg::STEP_ADDR;
                              end
                              twm_pkg::STEP_ADDR: begin
                                 if (s.dir) begin // RL9
                                    next_s.st = twm_pkg::TWM_RSTART; // RL14
                                 end else begin
                                    next_s.sh = s.wdata; // RL12
                                    next_s.step = twm_pkg::STEP_DATA;
                                 end
                              end
                              twm_pkg::STEP_DEV_RD: next_s.st = twm_pkg::TWM_RECV;
                              default: next_s.st = twm_pkg::TWM_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
            twm_pkg::TWM_STOP: begin
               case (s.q)
                  2'h0: next_s.sda_lo = 1'b1;
                  2'h1: next_s.scl_lo = 1'b0;
                  2'h2: next_s.sda_lo = 1'b0;
                  default: next_s.st = twm_pkg::TWM_IDLE; // RL13
               endcase
            end
            default: next_s.st = twm_pkg::TWM_IDLE;
         endcase
      end
      next_s.port_active = s.port_en & ~{3'h0, led_serial_en}; // RL4 RL5
      for (int p = 0; p < 4; p++) begin
         next_s.scl_oe_n[p] = !(next_s.port_active[p] && next_s.port_sel == 2'(p) && next_s.scl_lo); // RL4 RL7
      end
      next_s.sda_oe_n = !(next_s.port_active[next_s.port_sel] && next_s.sda_lo);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.dev <= twm_pkg::DEV_ADDR8_RST[7:1]; // RL1
         s.rate <= twm_pkg::RATE_RST; // RL3
         s.port_en <= twm_pkg::PORT_EN_RST;
         s.port_sel <= twm_pkg::PORT_SEL_RST;
         s.dir <= twm_pkg::DIR_RST;
         s.maddr <= twm_pkg::MADDR_RST;
         s.wdata <= twm_pkg::WDATA_RST;
         s.st <= twm_pkg::TWM_IDLE;
         s.scl_oe_n <= 4'hf;
         s.sda_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata      = s.rdata;
   assign port_serial_en = s.port_active;
   assign scl_o          = 4'h0;
   assign scl_oe_n       = s.scl_oe_n;
   assign sda_o          = 1'b0;
   assign sda_oe_n       = s.sda_oe_n;

   // assertion helpers: cycles between quarter ticks
   logic [9:0] gap;
   logic       tick_seen;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gap <= '0;
         tick_seen <= 1'b0;
      end else begin
         gap <= tick ? 10'h001 : gap + 10'h001;
         tick_seen <= (s.st != twm_pkg::TWM_IDLE) && (tick || tick_seen);
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_launch;
      s.st == twm_pkg::TWM_IDLE && s.exec && s.port_active[s.port_sel];
   endsequence

   sequence s_acked(logic [2:0] stp);
      byte_end && s.st == twm_pkg::TWM_SEND && !s.nack && s.step == stp;
   endsequence

   property p_dev_byte;
      s_launch |=> s.st == twm_pkg::TWM_START && s.sh == {s.dev, 1'b0};
   endproperty
   a_dev_byte: assert property (p_dev_byte) else $error("address byte not loaded at launch"); // RL1

   property p_rd_byte;
      s.st == twm_pkg::TWM_RSTART && tick && s.q == 2'h3 |=> s.sh == {s.dev, 1'b1};
   endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("read address byte lacks read bit"); // RL2

   property p_rate;
      tick && tick_seen |-> gap == twm_pkg::twm_quarter_cycles(s.rate);
   endproperty
   a_rate: assert property (p_rate) else $error("quarter period does not match rate"); // RL3

   property p_port_off;
      (~s.port_en & ~s.scl_oe_n) == 4'h0;
   endproperty
   a_port_off: assert property (p_port_off) else $error("disabled port drives clock"); // RL4

   property p_led;
      led_serial_en |=> !s.port_active[0] && s.scl_oe_n[0];
   endproperty
   a_led: assert property (p_led) else $error("port 0 serial while LED on"); // RL5

   property p_ready;
      reg_rd && reg_addr == twm_pkg::REG_CMD |=> reg_rdata[twm_pkg::CMD_READY] == $past(ready);
   endproperty
   a_ready: assert property (p_ready) else $error("ready flag read wrong"); // RL6

   property p_busy;
      reg_rd && reg_addr == twm_pkg::REG_CMD && s.st != twm_pkg::TWM_IDLE |=> !reg_rdata[twm_pkg::CMD_READY];
   endproperty
   a_busy: assert property (p_busy) else $error("ready read 1 during transfer"); // RL13

   property p_sel;
      s.st != twm_pkg::TWM_IDLE |-> (s.scl_oe_n | (4'h1 << s.port_sel)) == 4'hf;
   endproperty
   a_sel: assert property (p_sel) else $error("unselected port driven"); // RL7

   property p_exec;
      s.exec |=> !s.exec;
   endproperty
   a_exec: assert property (p_exec) else $error("execute bit not self-cleared"); // RL8

   property p_dir;
      s.st == twm_pkg::TWM_RSTART || s.st == twm_pkg::TWM_RECV |-> s.dir;
   endproperty
   a_dir: assert property (p_dir) else $error("read phase while direction is write"); // RL9

   property p_maddr;
      s_acked(twm_pkg::STEP_DEV) |=> s.sh == s.maddr && s.step == twm_pkg::STEP_ADDR;
   endproperty
   a_maddr: assert property (p_maddr) else $error("byte address not sent second"); // RL10

   property p_rx;
      $changed(s.rx) |-> $past(s.st) == twm_pkg::TWM_RECV && s.dir;
   endproperty
   a_rx: assert property (p_rx) else $error("read data changed outside a read"); // RL11

   property p_wdata;
      s_acked(twm_pkg::STEP_ADDR) ##0 !s.dir |=> s.sh == s.wdata;
   endproperty
   a_wdata: assert property (p_wdata) else $error("write byte not loaded"); // RL12

   property p_nack;
      s.st == twm_pkg::TWM_RECV && s.bitn == 4'h8 && s.q != 2'h0 |-> s.sda_oe_n;
   endproperty
   a_nack: assert property (p_nack) else $error("read byte acknowledged"); // RL14

endmodule // twm_serial_mux

// File: twm_slave_model.sv
`timescale 1ns/1ps

module twm_slave_model #(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic stretch,
   output logic      sda_pull_n,
   output logic      scl_hold_n
);
   logic [7:0] mem [256];
   logic [7:0] shreg;
   logic [7:0] maddr;
   logic [7:0] txb;
   logic [7:0] last_dev;
   logic       rd_mode;
   logic       ack;
   int         bitn;
   int         bytn;

   initial begin
      sda_pull_n = 1'b1;
      scl_hold_n = 1'b1;
      bitn = 0;
      bytn = 0;
      rd_mode = 1'b0;
      maddr = 8'h00;
      last_dev = 8'h00;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   end

   // start or repeated start: a new address phase follows
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = 0;
      bytn = 0;
      rd_mode = 1'b0;
   end

   // stop: let go of the data line
   always @(posedge sda) if (scl === 1'b1) begin
      bitn = 0;
      bytn = 0;
      rd_mode = 1'b0;
      sda_pull_n = 1'b1;
   end

   always @(posedge scl) begin
      if (bitn < 8) shreg = {shreg[6:0], sda};
      bitn++;
   end

   always @(negedge scl) begin
      // stretch past the master's high-phase sample, only where a data or ack bit follows
      if (stretch && bitn != 9) begin
         scl_hold_n = 1'b0;
         scl_hold_n <= #500 1'b1;
      end
      if (bitn == 8) begin
         if (bytn == 0) begin
            last_dev = shreg;
            rd_mode = shreg[0];
            ack = (shreg[7:1] == DEV_ADDR);
         end else begin
            ack = !rd_mode;
            if (!rd_mode && bytn == 1) maddr = shreg;
            if (!rd_mode && bytn == 2) mem[maddr] = shreg;
         end
         sda_pull_n = !ack;
         bytn++;
      end else if (bitn == 9) begin
         bitn = 0;
         txb = mem[maddr];
         // only the byte after a read address is driven; a not-acked byte frees the line for the stop
         sda_pull_n = (rd_mode && bytn == 1) ? txb[7] : 1'b1;
      end else if (rd_mode && bytn == 1) begin
         sda_pull_n = txb[7-bitn];
      end
   end
endmodule // twm_slave_model

// File: twm_serial_mux_test.sv
`timescale 1ns/1ps

module twm_serial_mux_test;
   logic        core_clk;
   logic        rstn;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        led_serial_en;
   logic [3:0]  port_serial_en;
   logic [3:0]  scl_o;
   logic [3:0]  scl_oe_n;
   logic        sda_o;
   logic        sda_oe_n;
   logic [3:0]  scl_w;
   logic        sda_w;
   logic        pull_n;
   logic        hold_n;
   logic        stretch;
   logic [3:0]  oe_q;
   logic [3:0]  act;
   logic [15:0] v;
   int          bad_count;
   int          checked;
   int          cyc;
   int          n;
   int          falls [4];
   int          fall_t [$];

   // open-drain wires with pull-ups
   assign scl_w = scl_oe_n & {4{hold_n}};
   assign sda_w = sda_oe_n & pull_n;

   twm_serial_mux dut_u (
      .core_clk      (core_clk),
      .rstn          (rstn),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .led_serial_en (led_serial_en),
      .port_serial_en(port_serial_en),
      .scl_i         (scl_w),
      .scl_o         (scl_o),
      .scl_oe_n      (scl_oe_n),
      .sda_i         (sda_w),
      .sda_o         (sda_o),
      .sda_oe_n      (sda_oe_n)
   );

   twm_slave_model slave_u (
      .scl       (&scl_w),
      .sda       (sda_w),
      .stretch   (stretch),
      .sda_pull_n(pull_n),
      .scl_hold_n(hold_n)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // counts clock-line falls per port and cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      for (int p = 0; p < 4; p++) begin
         if (oe_q[p] && !scl_oe_n[p]) begin
            falls[p]++;
            fall_t.push_back(cyc);
         end
      end
      oe_q = scl_oe_n;
      if (cyc > 90000) begin
         bad_count++;
         give_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask

   task automatic wait_ready;
      n = 0;
      do begin
         rd(twm_pkg::REG_CMD, v);
         n++;
      end while (v[15] !== 1'b1 && n < 12000);
      check(16'(n < 12000), 16'h0001);
   endtask

   // launch a transfer; rdy is the ready flag expected just after launch
   task automatic go(input logic [1:0] p, input logic dir, input logic [7:0] a, input logic rdy);
      fall_t.delete();
      falls = '{default: 0};
      wr(twm_pkg::REG_CMD, {4'h0, p, 1'b1, dir, a});
      rd(twm_pkg::REG_CMD, v);
      check(v, {rdy, 3'h0, p, 1'b0, dir, a});
   endtask

   function automatic int quarter(input int r);
      int f;
      f = (r == 0) ? 50 : (r == 1) ? 100 : (r == 2) ? 400 : 2000;
      return (twm_pkg::CLK_KHZ + 4 * f - 1) / (4 * f);
   endfunction

   initial begin
      rstn = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      led_serial_en = 1'b0;
      stretch = 1'b0;
      bad_count = 0;
      checked = 0;
      cyc = 0;
      oe_q = 4'hf;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      check({port_serial_en, scl_oe_n, sda_oe_n, scl_o, sda_o}, 16'h03e0);
      rd(twm_pkg::REG_CONFIG, v);
      check(v, 16'ha010);
      rd(twm_pkg::REG_CMD, v);
      check(v, 16'h8100);
      rd(twm_pkg::REG_DATA, v);
      check(v, 16'h0000);
      rd(5'h17, v);
      check(v, 16'h0000);
      wr(twm_pkg::REG_CONFIG, 16'ha1ff);
      rd(twm_pkg::REG_CONFIG, v);
      check(v, 16'ha03f);
      check(16'(port_serial_en), 16'h000f);
      @(posedge core_clk);
      led_serial_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(16'(port_serial_en), 16'h000e);
      led_serial_en <= 1'b0;
      // one write on each port at the top rate
      for (int p = 0; p < 4; p++) begin
         wr(twm_pkg::REG_DATA, {8'h00, 8'(8'h30 + p)});
         go(2'(p), 1'b0, 8'(8'h10 + p), 1'b0);
         if (p == 0) wr(twm_pkg::REG_DATA, 16'h00ff);
         wait_ready();
         check(16'(slave_u.mem[8'(8'h10 + p)]), 16'(8'h30 + p));
         for (int i = 0; i < 4; i++) act[i] = (falls[i] != 0);
         check(16'(act), 16'(4'h1 << p));
         rd(twm_pkg::REG_DATA, v);
         check(v, {8'h00, 8'(8'h30 + p)});
      end
      // read with the slave stretching the clock
      stretch = 1'b1;
      go(2'h2, 1'b1, 8'h42, 1'b0);
      wait_ready();
      stretch = 1'b0;
      // the held first bit lasts one quarter longer
      check(16'(fall_t[1] - fall_t[0]), 16'(5 * quarter(3)));
      rd(twm_pkg::REG_DATA, v);
      check(v, {8'h42 ^ 8'h5a, 8'h33});
      check(16'(slave_u.last_dev), 16'h00a1);
      // launch on a disabled port and on the port taken by the LED function
      wr(twm_pkg::REG_CONFIG, 16'ha035);
      go(2'h1, 1'b0, 8'h20, 1'b1);
      check(16'(falls[1]), 16'h0000);
      check(16'(slave_u.mem[8'h20]), 16'(8'h20 ^ 8'h5a));
      @(posedge core_clk);
      led_serial_en <= 1'b1;
      go(2'h0, 1'b0, 8'h20, 1'b1);
      check(16'(falls[0]), 16'h0000);
      led_serial_en <= 1'b0;
      // every rate, with a device address nobody answers
      for (int r = 0; r < 4; r++) begin
         wr(twm_pkg::REG_CONFIG, {7'h51, 3'h0, 2'(r), 4'h1});
         go(2'h0, 1'b0, 8'h50, 1'b0);
         wait_ready();
         check(16'(fall_t[2] - fall_t[1]), 16'(4 * quarter(r)));
         check(16'(slave_u.last_dev), 16'h00a2);
         rd(twm_pkg::REG_DATA, v);
         check(v, {8'h42 ^ 8'h5a, 8'h33});
      end
      give_verdict();
   end
endmodule // twm_serial_mux_test
